// >>> rtl/pch_params.svh
`ifndef PCH_PARAMS_SVH
`define PCH_PARAMS_SVH

// configuration offsets, byte addresses
`define PCH_OFF_CMD_STAT 8'h04
`define PCH_OFF_CLASS 8'h08
`define PCH_OFF_MEM_BASE 8'h10
`define PCH_OFF_IO_BASE 8'h14
`define PCH_OFF_ROM_BASE 8'h30
`define PCH_OFF_INT 8'h3c

// field positions
`define PCH_CMD_IO_BIT 0
`define PCH_CMD_MEM_BIT 1
`define PCH_DEVSEL_LSB 25
`define PCH_CLASS_LSB 8
`define PCH_BASE_LSB 24
`define PCH_PREFETCH_BIT 3
`define PCH_IO_BASE_LSB 10
`define PCH_INT_PIN_LSB 8

// fixed values
`define PCH_DEVSEL_FAST 2'h0
`define PCH_CLASS_CODE 24'h030000
`define PCH_INT_PIN_INTA 8'h01
`define PCH_INT_PIN_NONE 8'h00
`define PCH_BIOS_SEG_TAG 17'h00018

// reset values
`define PCH_RST_BASE8 8'h00
`define PCH_RST_IO_BASE 6'h00
`define PCH_RST_INT_LINE 8'h00

`endif

// >>> rtl/pch_pkg.sv
package pch_pkg;
   typedef struct packed {
      logic s1Pci;
      logic s2Pci;
      logic s1Rel;
      logic s2Rel;
      logic s1Int;
      logic s2Int;
      logic cmdIo;
      logic cmdMem;
      logic [7:0] memBase;
      logic [5:0] ioBase;
      logic [7:0] romBase;
      logic romEn;
      logic [7:0] intLine;
      logic ack;
      logic [31:0] rdata;
      logic memHit;
      logic romHit;
      logic biosHit;
      logic [1:0] aperture;
      logic ioHit;
      logic [8:0] ioOffset;
   } pch_state_t;
endpackage

// >>> rtl/pch_config_header.sv
// Function
// [R1] The target-select timing field at status bits 26:25 always reads 00 and is read-only.
// [R2] The class word bits 31:8 read the fixed class code 03/00/00 for a display controller.
// [R3] The class word bits 7:0 read a fixed revision number that software should not act on.
// [R4] Display-memory base bits 31:24 are stored and memory cycles are decoded against them.
// [R5] The basic variant claims only the first 4 Mbytes; the enhanced one all 16 as 4 apertures.
// [R6] Where supported, display-memory base bit 3 always reads one to mark prefetchable.
// [R7] Display-memory base bit 0 always reads zero to mark a memory space.
// [R8] I/O base bits 15:10 are stored and the 512-byte I/O range is decoded relative to them.
// [R9] I/O base bit 0 shows the relocation strap and gates relocated I/O decoding.
// [R10] Expansion ROM base bits 31:24 are stored and the boot ROM is mapped there.
// [R11] With the ROM enable set the boot ROM is served at C000:0 and column strobe 0 is held high.
// [R12] The interrupt line byte is read/write storage with no effect on the device.
// [R13] The interrupt pin byte reads 01 with the interrupt strap pulled down, else 00.
// [R14] All registers exist and act only while the device is strapped for PCI.
// [R15] Memory cycles are claimed only while command bit 1 is one.
// [R16] Reserved bits read zero and writes to reserved or read-only bits are ignored.
`include "pch_params.svh"

module pch_config_header #(
   parameter bit ENHANCED = 1'b0,
   parameter bit HAS_PREFETCH = 1'b1,
   parameter logic [7:0] REVISION_ID = 8'h5a // arbitrary value
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic pciStrap,
   input wire logic io_relocate_strap,
   input wire logic interrupt_pin_strap,
   input wire logic cfgSel,
   input wire logic cfgRead,
   input wire logic cfgWrite,
   input wire logic [7:2] cfgAddr,
   input wire logic [3:0] cfgByteEn,
   input wire logic [31:0] cfgWdata,
   output logic cfgAck,
   output logic [31:0] cfgRdata,
   input wire logic memReq,
   input wire logic [31:0] memAddr,
   output logic memHit,
   output logic [1:0] memAperture,
   output logic romHit,
   output logic biosSegHit,
   output logic memory_column_strobe_zero_force,
   input wire logic ioReq,
   input wire logic [15:0] ioAddr,
   output logic ioHit,
   output logic [8:0] ioOffset,
   output logic cfgPresent,
   output logic ioRelocEnabled,
   output logic [7:0] interruptLine
);
   import pch_pkg::*;

   if (ENHANCED && HAS_PREFETCH)
   begin : g_prefetchCheck
      $error("prefetch bit exists only on the basic variant");
   end

   pch_state_t st_r;
   pch_state_t st_nxt;

   function automatic logic [7:0] mergeByte(input logic [7:0] old, input logic [7:0] wd,
                                            input logic en);
      mergeByte = en ? wd : old;
   endfunction

   function automatic logic [31:0] readWord(input pch_state_t s, input logic [7:2] a);
      logic [31:0] w;
      w = 32'h00000000;
      if (a == `PCH_OFF_CMD_STAT >> 2)
      begin
         w[`PCH_CMD_IO_BIT] = s.cmdIo;
         w[`PCH_CMD_MEM_BIT] = s.cmdMem;
         w[`PCH_DEVSEL_LSB +: 2] = `PCH_DEVSEL_FAST; // R1
      end
      else if (a == `PCH_OFF_CLASS >> 2)
         w = {`PCH_CLASS_CODE, REVISION_ID}; // R2 R3
      else if (a == `PCH_OFF_MEM_BASE >> 2)
      begin
         w[`PCH_BASE_LSB +: 8] = s.memBase;
         w[`PCH_PREFETCH_BIT] = HAS_PREFETCH; // R6
         w[0] = 1'b0; // R7
      end
      else if (a == `PCH_OFF_IO_BASE >> 2)
      begin
         w[`PCH_IO_BASE_LSB +: 6] = s.ioBase;
         w[0] = s.s2Rel; // R9
      end
      else if (a == `PCH_OFF_ROM_BASE >> 2)
      begin
         w[`PCH_BASE_LSB +: 8] = s.romBase;
         w[0] = s.romEn;
      end
      else if (a == `PCH_OFF_INT >> 2)
      begin
         w[7:0] = s.intLine;
         w[`PCH_INT_PIN_LSB +: 8] = s.s2Int ? `PCH_INT_PIN_INTA : `PCH_INT_PIN_NONE; // R13
      end
      readWord = w; // R16
   endfunction

   always_comb
   begin
      logic take;
      logic memWin;
      logic romWin;
      logic biosWin;
      take = 1'b0;
      memWin = 1'b0;
      romWin = 1'b0;
      biosWin = 1'b0;
      st_nxt = st_r;
      // straps: active when pulled down, two-stage sync
      st_nxt.s1Pci = ~pciStrap;
      st_nxt.s2Pci = st_r.s1Pci;
      st_nxt.s1Rel = ~io_relocate_strap;
      st_nxt.s2Rel = st_r.s1Rel;
      st_nxt.s1Int = ~interrupt_pin_strap;
      st_nxt.s2Int = st_r.s1Int;

      take = cfgSel && (cfgRead || cfgWrite) && st_r.s2Pci; // R14
      st_nxt.ack = take;
      st_nxt.rdata = (take && cfgRead) ? readWord(st_r, cfgAddr) : 32'h00000000;
      if (take && cfgWrite)
      begin
         if (cfgAddr == `PCH_OFF_CMD_STAT >> 2 && cfgByteEn[0])
         begin
            st_nxt.cmdIo = cfgWdata[`PCH_CMD_IO_BIT];
            st_nxt.cmdMem = cfgWdata[`PCH_CMD_MEM_BIT];
         end
         if (cfgAddr == `PCH_OFF_MEM_BASE >> 2)
            st_nxt.memBase = mergeByte(st_r.memBase, cfgWdata[31:24], cfgByteEn[3]); // R4
         if (cfgAddr == `PCH_OFF_IO_BASE >> 2 && cfgByteEn[1])
            st_nxt.ioBase = cfgWdata[15:10]; // R8
         if (cfgAddr == `PCH_OFF_ROM_BASE >> 2)
         begin
            st_nxt.romBase = mergeByte(st_r.romBase, cfgWdata[31:24], cfgByteEn[3]); // R10
            if (cfgByteEn[0])
               st_nxt.romEn = cfgWdata[0];
         end
         if (cfgAddr == `PCH_OFF_INT >> 2)
            st_nxt.intLine = mergeByte(st_r.intLine, cfgWdata[7:0], cfgByteEn[0]); // R12
      end

      memWin = memAddr[31:24] == st_r.memBase && (ENHANCED || memAddr[23:22] == 2'h0); // R5
      romWin = st_r.romEn && memAddr[31:24] == st_r.romBase; // R10
      biosWin = memAddr[31:15] == `PCH_BIOS_SEG_TAG;
      // memory cycles need pci strap and memory enable
      st_nxt.memHit = memReq && st_r.s2Pci && st_r.cmdMem && memWin && !romWin; // R15 R4
      st_nxt.romHit = memReq && st_r.s2Pci && st_r.cmdMem && st_r.romEn && romWin; // R10
      st_nxt.biosHit = memReq && st_r.s2Pci && st_r.cmdMem && st_r.romEn && biosWin; // R11
      st_nxt.aperture = ENHANCED ? memAddr[23:22] : 2'h0; // R5
      st_nxt.ioHit = ioReq && st_r.s2Pci && st_r.cmdIo && st_r.s2Rel
                     && ioAddr[15:10] == st_r.ioBase && !ioAddr[9]; // R8 R9
      st_nxt.ioOffset = ioAddr[8:0];
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r <= '0;
         st_r.memBase <= `PCH_RST_BASE8;
         st_r.romBase <= `PCH_RST_BASE8;
         st_r.ioBase <= `PCH_RST_IO_BASE;
         st_r.intLine <= `PCH_RST_INT_LINE;
      end
      else
         st_r <= st_nxt;
   end

   assign cfgAck = st_r.ack;
   assign cfgRdata = st_r.rdata;
   assign memHit = st_r.memHit;
   assign memAperture = st_r.aperture;
   assign romHit = st_r.romHit;
   assign biosSegHit = st_r.biosHit;
   assign memory_column_strobe_zero_force = st_r.s2Pci && st_r.romEn; // R11
   assign ioHit = st_r.ioHit;
   assign ioOffset = st_r.ioOffset;
   assign cfgPresent = st_r.s2Pci;
   assign ioRelocEnabled = st_r.s2Pci && st_r.s2Rel; // R9
   assign interruptLine = st_r.intLine;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   sequence s_rdReq(logic [5:0] a);
      cfgSel && cfgRead && cfgPresent && cfgAddr == a;
   endsequence

   property p_devsel;
      s_rdReq(6'h01) |=> cfgAck && cfgRdata[26:25] == 2'h0 && cfgRdata[31:27] == 5'h00;
   endproperty
   a_devsel: assert property (p_devsel) else $error("devsel field not zero"); // R1

   property p_class;
      s_rdReq(6'h02) |=> cfgRdata == {24'h030000, REVISION_ID};
   endproperty
   a_class: assert property (p_class) else $error("class word wrong"); // R2

   property p_memBits;
      s_rdReq(6'h04) |=> cfgRdata[0] == 1'b0 && cfgRdata[3] == HAS_PREFETCH
                         && cfgRdata[23:4] == 20'h00000;
   endproperty
   a_memBits: assert property (p_memBits) else $error("memory base fixed bits wrong"); // R6

   sequence s_memBaseWr;
      cfgSel && cfgWrite && cfgPresent && cfgAddr == 6'h04 && cfgByteEn[3];
   endsequence

   property p_memBaseStore;
      s_memBaseWr |=> st_r.memBase == $past(cfgWdata[31:24]);
   endproperty
   a_memBaseStore: assert property (p_memBaseStore) else $error("memory base not stored"); // R4

   property p_absent;
      !cfgPresent |=> !cfgAck;
   endproperty
   a_absent: assert property (p_absent) else $error("answered while not pci"); // R14

   property p_memEnable;
      !st_r.cmdMem |=> !memHit && !romHit && !biosSegHit;
   endproperty
   a_memEnable: assert property (p_memEnable) else $error("memory claimed while disabled"); // R15

   property p_basicWindow;
      !ENHANCED && memReq && memAddr[23:22] != 2'h0 |=> !memHit;
   endproperty
   a_basicWindow: assert property (p_basicWindow) else $error("claimed above 4 Mbytes"); // R5

   property p_intPin;
      s_rdReq(6'h0f) ##1 cfgAck |-> cfgRdata[15:8] == ($past(st_r.s2Int, 1) ? 8'h01 : 8'h00);
   endproperty
   a_intPin: assert property (p_intPin) else $error("interrupt pin byte wrong"); // R13

   property p_casForce;
      cfgPresent && st_r.romEn |-> memory_column_strobe_zero_force;
   endproperty
   a_casForce: assert property (p_casForce) else $error("column strobe not forced"); // R11

   property p_ioGate;
      !ioRelocEnabled |=> !ioHit;
   endproperty
   a_ioGate: assert property (p_ioGate) else $error("io decoded without relocation"); // R9

   sequence s_take;
      cfgSel && (cfgRead || cfgWrite) && cfgPresent;
   endsequence

   property p_ackPulse;
      s_take |=> cfgAck;
   endproperty
   a_ackPulse: assert property (p_ackPulse) else $error("request not answered"); // R14

   property p_ackOnlyOnReq;
      !(cfgSel && (cfgRead || cfgWrite)) |=> !cfgAck;
   endproperty
   a_ackOnlyOnReq: assert property (p_ackOnlyOnReq) else $error("answer without request"); // R14

   property p_rdataIdle;
      !cfgAck |-> cfgRdata == 32'h00000000;
   endproperty
   a_rdataIdle: assert property (p_rdataIdle) else $error("read data outside answer"); // R16

   property p_ioBaseStore;
      cfgSel && cfgWrite && cfgPresent && cfgAddr == 6'h05 && cfgByteEn[1]
         |=> st_r.ioBase == $past(cfgWdata[15:10]);
   endproperty
   a_ioBaseStore: assert property (p_ioBaseStore) else $error("io base not stored"); // R8

   property p_romBaseStore;
      cfgSel && cfgWrite && cfgPresent && cfgAddr == 6'h0c && cfgByteEn[3]
         |=> st_r.romBase == $past(cfgWdata[31:24]);
   endproperty
   a_romBaseStore: assert property (p_romBaseStore) else $error("rom base not stored"); // R10

   property p_intLineStore;
      cfgSel && cfgWrite && cfgPresent && cfgAddr == 6'h0f && cfgByteEn[0]
         |=> interruptLine == $past(cfgWdata[7:0]);
   endproperty
   a_intLineStore: assert property (p_intLineStore) else $error("line byte not stored"); // R12

   property p_memBaseKeep;
      !(cfgSel && cfgWrite && cfgPresent && cfgAddr == 6'h04 && cfgByteEn[3])
         |=> $stable(st_r.memBase);
   endproperty
   a_memBaseKeep: assert property (p_memBaseKeep) else $error("memory base changed"); // R16

   property p_romGate;
      !st_r.romEn |=> !romHit && !biosSegHit;
   endproperty
   a_romGate: assert property (p_romGate) else $error("rom served while disabled"); // R11

   property p_ioOffset;
      ioReq |=> ioOffset == $past(ioAddr[8:0]);
   endproperty
   a_ioOffset: assert property (p_ioOffset) else $error("io offset wrong"); // R8

   property p_ioWindow;
      ioReq && ioAddr[9] |=> !ioHit;
   endproperty
   a_ioWindow: assert property (p_ioWindow) else $error("io claimed outside 512 bytes"); // R8

   property p_romWins;
      !(memHit && romHit);
   endproperty
   a_romWins: assert property (p_romWins) else $error("display and rom both claimed"); // R10
endmodule

// >>> testbench/pch_host_model.sv
module pch_host_model (
   input wire logic core_clk,
   input wire logic cfgAck,
   input wire logic [31:0] cfgRdata,
   output logic cfgSel,
   output logic cfgRead,
   output logic cfgWrite,
   output logic [7:2] cfgAddr,
   output logic [3:0] cfgByteEn,
   output logic [31:0] cfgWdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      {cfgSel, cfgRead, cfgWrite} = 3'h0;
      {cfgAddr, cfgByteEn, cfgWdata} = '0;
   end
   // one request, taken at the next rising edge, answer read half a cycle later at the falling edge
   task automatic xfer(input logic wr, input logic [5:0] a, input logic [3:0] be,
      input logic [31:0] wd, output logic ok, output logic [31:0] rd);
      @(negedge core_clk);
      {cfgSel, cfgRead, cfgWrite} = {1'b1, !wr, wr};
      {cfgAddr, cfgByteEn, cfgWdata} = {a, be, wd};
      @(negedge core_clk);
      ok = cfgAck;
      rd = cfgRdata;
      {cfgSel, cfgRead, cfgWrite} = 3'h0;
      // released address and write data lines show an inverted pattern
      {cfgAddr, cfgWdata} = {~a, ~wd};
   endtask
endmodule

// >>> testbench/pch_config_header_bench.sv
module pch_config_header_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0, nrst = 1'b0, pciStrap = 1'b0, memReq = 1'b0, ioReq = 1'b0;
   logic io_relocate_strap = 1'b0, interrupt_pin_strap = 1'b0, mRomEn, eM, eB, eI, eR;
   logic cfgSel, cfgRead, cfgWrite, cfgAck, memHit, romHit, biosSegHit, ioHit;
   logic memory_column_strobe_zero_force, cfgPresent, ioRelocEnabled;
   logic [7:2] cfgAddr;
   logic [3:0] cfgByteEn;
   logic [31:0] cfgWdata, cfgRdata, memAddr = 32'h0, seed = 32'h4b42, r, q;
   logic [1:0] memAperture, mCmd;
   logic [15:0] ioAddr = 16'h0;
   logic [8:0] ioOffset, eO;
   logic [7:0] interruptLine, mMem, mRom, mInt;
   logic [5:0] mIo;
   logic [5:0] tbl [8] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h0c, 6'h0f, 6'h00, 6'h03};
   int n_mismatch = 0, num_checks = 0;
   always #20 core_clk = ~core_clk;
   pch_config_header pch_config_header_inst (.core_clk, .nrst, .pciStrap, .io_relocate_strap,
      .interrupt_pin_strap, .cfgSel, .cfgRead, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWdata,
      .cfgAck, .cfgRdata, .memReq, .memAddr, .memHit, .memAperture, .romHit, .biosSegHit,
      .memory_column_strobe_zero_force, .ioReq, .ioAddr, .ioHit, .ioOffset, .cfgPresent,
      .ioRelocEnabled, .interruptLine);
   pch_host_model pch_host_model_inst (.core_clk, .cfgAck, .cfgRdata, .cfgSel, .cfgRead,
      .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWdata);
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] expRd(input logic [5:0] a);
      case (a)
         6'h01: return {30'h0, mCmd};
         6'h02: return 32'h0300005a;
         6'h04: return {mMem, 24'h000008};
         6'h05: return {16'h0, mIo, 9'h0, !io_relocate_strap};
         6'h0c: return {mRom, 23'h0, mRomEn};
         6'h0f: return {23'h0, !interrupt_pin_strap, mInt};
         default: return 32'h0;
      endcase
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rw(input logic wr, input logic [5:0] a, input logic [3:0] be,
      input logic [31:0] wd);
      logic ok;
      logic [31:0] rd, e;
      e = pciStrap ? 32'h0 : expRd(a);
      pch_host_model_inst.xfer(wr, a, be, wd, ok, rd);
      chk("cfgAck", !pciStrap, ok);
      chk("cfgPresent", !pciStrap, cfgPresent);
      if (!wr)
         chk("cfgRdata", e, rd);
      else if (!pciStrap)
      begin
         if (a == 6'h01 && be[0]) mCmd = wd[1:0];
         if (a == 6'h04 && be[3]) mMem = wd[31:24];
         if (a == 6'h05 && be[1]) mIo = wd[15:10];
         if (a == 6'h0c && be[3]) mRom = wd[31:24];
         if (a == 6'h0c && be[0]) mRomEn = wd[0];
         if (a == 6'h0f && be[0]) mInt = wd[7:0];
      end
   endtask
   task automatic dec(input int n);
      for (int i = 0; i < n; i++)
      begin
         r = xs();
         q = xs();
         {memReq, ioReq} = r[1:0];
         memAddr = r[2] ? {16'h000c, r[3], q[14:0]}
            : {r[4] ? (r[6] ? mRom : mMem) : q[31:24], q[23:0]};
         ioAddr = {r[5] ? mIo : q[15:10], q[9:0]};
         eM = memReq && !pciStrap && mCmd[1] && memAddr[31:22] == {mMem, 2'h0}
            && !(mRomEn && memAddr[31:24] == mRom);
         eR = memReq && !pciStrap && mCmd[1] && mRomEn && memAddr[31:24] == mRom;
         eB = memReq && !pciStrap && mCmd[1] && mRomEn && memAddr[31:15] == 17'h00018;
         eI = ioReq && !pciStrap && mCmd[0] && !io_relocate_strap && !ioAddr[9]
            && ioAddr[15:10] == mIo;
         eO = ioAddr[8:0];
         @(negedge core_clk);
         chk("memHit", eM, memHit);
         chk("biosSegHit", eB, biosSegHit);
         chk("romHit", eR, romHit);
         chk("ioHit", eI, ioHit);
         if (eI) chk("ioOffset", eO, ioOffset);
         chk("memAperture", 32'h0, memAperture);
      end
      {memReq, ioReq} = 2'h0;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      {mCmd, mMem, mRom, mInt, mIo, mRomEn} = '0;
      repeat (5) @(negedge core_clk);
      nrst = 1'b1;
      repeat (3) @(negedge core_clk);
      for (int a = 0; a < 16; a++)
         rw(1'b0, 6'(a), 4'hf, 32'h0);
      $display("reset values done");
      for (int i = 0; i < 60; i++)
      begin
         r = xs();
         rw(1'b1, tbl[r[2:0]], r[7:4], xs());
         rw(1'b0, tbl[r[2:0]], 4'hf, 32'h0);
         chk("interruptLine", mInt, interruptLine);
      end
      $display("random access done");
      for (int p = 0; p < 4; p++)
      begin
         r = xs();
         rw(1'b1, 6'h01, 4'h1, 32'(p));
         rw(1'b1, 6'h04, 4'h8, 32'h40000000);
         rw(1'b1, 6'h0c, 4'h9, {8'h80, 23'h0, p == 3});
         rw(1'b1, 6'h05, 4'h2, r);
         chk("strobeForce", mRomEn, memory_column_strobe_zero_force);
         dec(40);
      end
      $display("decode done");
      for (int s = 0; s < 4; s++)
      begin
         {io_relocate_strap, interrupt_pin_strap} = 2'(s);
         repeat (3) @(negedge core_clk);
         rw(1'b0, 6'h05, 4'hf, 32'h0);
         rw(1'b0, 6'h0f, 4'hf, 32'h0);
         chk("ioRelocEnabled", !io_relocate_strap, ioRelocEnabled);
         dec(10);
      end
      $display("straps done");
      nrst = 1'b0;
      repeat (2) @(negedge core_clk);
      {mCmd, mMem, mRom, mInt, mIo, mRomEn} = '0;
      nrst = 1'b1;
      repeat (3) @(negedge core_clk);
      for (int a = 0; a < 16; a++)
         rw(1'b0, 6'(a), 4'hf, 32'h0);
      $display("mid reset done");
      pciStrap = 1'b1;
      repeat (3) @(negedge core_clk);
      rw(1'b1, 6'h0f, 4'h1, 32'h77);
      dec(20);
      pciStrap = 1'b0;
      repeat (3) @(negedge core_clk);
      rw(1'b0, 6'h0f, 4'hf, 32'h0);
      $display("absent bus done");
      print_verdict();
   end
endmodule
